// file: core/gpm_pkg.sv
// Package for the two-port pin mux and general I/O block.
// Assumes a 32-bit APB slave, one clock, word-aligned registers.
package gpm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FUNC_SEL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_P1_DIR     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_P1_DATA    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_P1_PULLUP  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_P2_DIR     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_P2_DATA    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_P2_OD      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SER_CTRL   = 8'h1c;

  // Reset values
  localparam logic [PORT_W-1:0] RST_CTRL       = 8'h00;
  localparam logic [3:0]        RST_SER        = 4'h0;

  // Bits that are reserved and read as one
  localparam logic [PORT_W-1:0] P1_RSVD_MASK   = 8'h08;
  localparam logic [PORT_W-1:0] P2_OD_RSVD     = 8'h07;

  // Function select bit positions
  localparam int unsigned FS_EXT_INTERRUPT_THREE  = 7;
  localparam int unsigned FS_EXT_INTERRUPT_TWO  = 6;
  localparam int unsigned FS_EXT_INTERRUPT_ONE  = 5;
  localparam int unsigned FS_EXT_INTERRUPT_ZERO  = 4;
  localparam int unsigned FS_TXD2  = 3;
  localparam int unsigned FS_PWM   = 2;
  localparam int unsigned FS_TXD   = 1;
  localparam int unsigned FS_CLOCK_TIMER_OUTPUT  = 0;

  // Serial control bit positions
  localparam int unsigned SC_RE    = 0;
  localparam int unsigned SC_CLOCK_ENABLE_LO  = 1;
  localparam int unsigned SC_CLOCK_ENABLE_HI  = 2;
  localparam int unsigned SC_COM   = 3;

  // Pin positions with peripheral use
  localparam int unsigned P1_PWM_BIT  = 1;
  localparam int unsigned P1_CLOCK_TIMER_OUTPUT_BIT = 0;
  localparam int unsigned P2_TXD_BIT  = 2;
  localparam int unsigned P2_RXD_BIT  = 1;
  localparam int unsigned P2_SCK_BIT  = 0;

  // Signals from peripherals toward the pins
  typedef struct packed {
    logic pwm;
    logic clock_timer_output;
    logic txd;
    logic txd2;
    logic sck_out;
  } gpm_periph_in_s;

  // Signals from the pins toward peripherals
  typedef struct packed {
    logic ext_interrupt_three;
    logic timer_trigger_input;
    logic ext_interrupt_two;
    logic ext_interrupt_one;
    logic timer_b_event_input;
    logic ext_interrupt_zero;
    logic rxd;
    logic sck_in;
    logic txd2_sel;
    logic txd2;
  } gpm_periph_out_s;

endpackage

// file: core/gpm_ports.sv
// Port one and port two general I/O with peripheral pin mux.
// Assumes an APB master on pclk; pin inputs already synchronous.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module gpm_ports (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [gpm_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [gpm_pkg::PORT_W-1:0]      p1_in,
  output logic      [gpm_pkg::PORT_W-1:0]      p1_out,
  output logic      [gpm_pkg::PORT_W-1:0]      p1_oe_n,
  output logic      [gpm_pkg::PORT_W-1:0]      p1_pullup_on,
  input  wire logic [gpm_pkg::PORT_W-1:0]      p2_in,
  output logic      [gpm_pkg::PORT_W-1:0]      p2_out,
  output logic      [gpm_pkg::PORT_W-1:0]      p2_oe_n,
  input  wire gpm_pkg::gpm_periph_in_s         periph_in,
  output gpm_pkg::gpm_periph_out_s             periph_out
);

  logic [gpm_pkg::PORT_W-1:0] func_sel_reg;
  logic [gpm_pkg::PORT_W-1:0] p1_dir_reg;
  logic [gpm_pkg::PORT_W-1:0] p1_data_reg;
  logic [gpm_pkg::PORT_W-1:0] p1_pu_reg;
  logic [gpm_pkg::PORT_W-1:0] p2_dir_reg;
  logic [gpm_pkg::PORT_W-1:0] p2_data_reg;
  logic [gpm_pkg::PORT_W-1:0] p2_od_reg;
  logic [3:0]                 ser_ctrl_reg;

  logic                       wr_en;
  logic                       wr_func_sel;
  logic                       wr_p1_dir;
  logic                       wr_p1_data;
  logic                       wr_p1_pu;
  logic                       wr_p2_dir;
  logic                       wr_p2_data;
  logic                       wr_p2_od;
  logic                       wr_ser_ctrl;
  logic                       rd_en;
  logic [gpm_pkg::PORT_W-1:0] wbyte;
  logic [31:0]                rdata_next;
  logic                       mapped;

  logic [gpm_pkg::PORT_W-1:0] p1_out_next;
  logic [gpm_pkg::PORT_W-1:0] p1_oe_n_next;
  logic [gpm_pkg::PORT_W-1:0] p1_pu_next;
  logic [gpm_pkg::PORT_W-1:0] p2_out_next;
  logic [gpm_pkg::PORT_W-1:0] p2_oe_n_next;
  logic [gpm_pkg::PORT_W-1:0] p1_gpio;
  logic [gpm_pkg::PORT_W-1:0] p2_gpio;
  logic                       sck_in_sel;
  logic                       sck_out_sel;
  gpm_pkg::gpm_periph_out_s   periph_next;

  // One wait state: answer in the cycle after the first access cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;
  assign wbyte = pwdata[gpm_pkg::PORT_W-1:0];

  // Per-register write strobes, taken at the sampled-ready edge
  assign wr_func_sel = wr_en & (paddr == gpm_pkg::OFS_FUNC_SEL);
  assign wr_p1_dir   = wr_en & (paddr == gpm_pkg::OFS_P1_DIR);
  assign wr_p1_data  = wr_en & (paddr == gpm_pkg::OFS_P1_DATA);
  assign wr_p1_pu    = wr_en & (paddr == gpm_pkg::OFS_P1_PULLUP);
  assign wr_p2_dir   = wr_en & (paddr == gpm_pkg::OFS_P2_DIR);
  assign wr_p2_data  = wr_en & (paddr == gpm_pkg::OFS_P2_DATA);
  assign wr_p2_od    = wr_en & (paddr == gpm_pkg::OFS_P2_OD);
  assign wr_ser_ctrl = wr_en & (paddr == gpm_pkg::OFS_SER_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      gpm_pkg::OFS_FUNC_SEL: begin
        rdata_next[gpm_pkg::PORT_W-1:0] = func_sel_reg;
      end
      gpm_pkg::OFS_P1_DIR: begin
        rdata_next = 32'h0000_0000;
      end
      gpm_pkg::OFS_P1_DATA: begin
        rdata_next[gpm_pkg::PORT_W-1:0] =
          (p1_dir_reg & p1_data_reg) | (~p1_dir_reg & p1_in) | gpm_pkg::P1_RSVD_MASK;
      end
      gpm_pkg::OFS_P1_PULLUP: begin
        rdata_next[gpm_pkg::PORT_W-1:0] = p1_pu_reg | gpm_pkg::P1_RSVD_MASK;
      end
      gpm_pkg::OFS_P2_DIR: begin
        rdata_next = 32'h0000_0000;
      end
      gpm_pkg::OFS_P2_DATA: begin
        rdata_next[gpm_pkg::PORT_W-1:0] = (p2_dir_reg & p2_data_reg) | (~p2_dir_reg & p2_in);
      end
      gpm_pkg::OFS_P2_OD: begin
        rdata_next[gpm_pkg::PORT_W-1:0] = p2_od_reg | gpm_pkg::P2_OD_RSVD;
      end
      gpm_pkg::OFS_SER_CTRL: begin
        rdata_next[3:0] = ser_ctrl_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= rd_en ? rdata_next : 32'h0000_0000;
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_func_sel) begin
      func_sel_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_dir_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p1_dir) begin
      p1_dir_reg <= wbyte & ~gpm_pkg::P1_RSVD_MASK;
    end
  end

  // port-one data, reserved bit held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_data_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p1_data) begin
      p1_data_reg <= wbyte & ~gpm_pkg::P1_RSVD_MASK;
    end
  end

  // port-one pull-up, reserved bit held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_pu_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p1_pu) begin
      p1_pu_reg <= wbyte & ~gpm_pkg::P1_RSVD_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_dir_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p2_dir) begin
      p2_dir_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_data_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p2_data) begin
      p2_data_reg <= wbyte;
    end
  end

  // open-drain select, reserved bits held low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_od_reg <= gpm_pkg::RST_CTRL;
    end else if (wr_p2_od) begin
      p2_od_reg <= wbyte & ~gpm_pkg::P2_OD_RSVD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_ctrl_reg <= gpm_pkg::RST_SER;
    end else if (wr_ser_ctrl) begin
      ser_ctrl_reg <= pwdata[3:0];
    end
  end

  assign sck_in_sel  = ser_ctrl_reg[gpm_pkg::SC_CLOCK_ENABLE_HI];
  assign sck_out_sel = ~sck_in_sel &
                       (ser_ctrl_reg[gpm_pkg::SC_CLOCK_ENABLE_LO] | ser_ctrl_reg[gpm_pkg::SC_COM]);

  always_comb begin
    p1_gpio = 8'hff & ~gpm_pkg::P1_RSVD_MASK;
    p1_gpio[gpm_pkg::FS_EXT_INTERRUPT_THREE] = ~func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_THREE];
    p1_gpio[gpm_pkg::FS_EXT_INTERRUPT_TWO] = ~func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_TWO];
    p1_gpio[gpm_pkg::FS_EXT_INTERRUPT_ONE] = ~func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_ONE];
    p1_gpio[gpm_pkg::FS_EXT_INTERRUPT_ZERO] = ~func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_ZERO];
    p1_gpio[gpm_pkg::P1_PWM_BIT]  = ~func_sel_reg[gpm_pkg::FS_PWM];
    p1_gpio[gpm_pkg::P1_CLOCK_TIMER_OUTPUT_BIT] = ~func_sel_reg[gpm_pkg::FS_CLOCK_TIMER_OUTPUT];
  end

  // port-two pins taken by the serial channel
  always_comb begin
    p2_gpio = 8'hff;
    p2_gpio[gpm_pkg::P2_TXD_BIT] = ~func_sel_reg[gpm_pkg::FS_TXD];
    p2_gpio[gpm_pkg::P2_RXD_BIT] = ~ser_ctrl_reg[gpm_pkg::SC_RE];
    p2_gpio[gpm_pkg::P2_SCK_BIT] = ~(sck_in_sel | sck_out_sel);
  end

  always_comb begin
    p1_out_next  = p1_data_reg & p1_gpio;
    p1_oe_n_next = ~(p1_dir_reg & p1_gpio);
    p1_pu_next   = p1_pu_reg & ~p1_dir_reg & ~gpm_pkg::P1_RSVD_MASK;
    // PWM drives pin regardless of direction
    if (func_sel_reg[gpm_pkg::FS_PWM]) begin
      p1_out_next[gpm_pkg::P1_PWM_BIT]  = periph_in.pwm;
      p1_oe_n_next[gpm_pkg::P1_PWM_BIT] = 1'b0;
    end
    // clock timer drives pin regardless of direction
    if (func_sel_reg[gpm_pkg::FS_CLOCK_TIMER_OUTPUT]) begin
      p1_out_next[gpm_pkg::P1_CLOCK_TIMER_OUTPUT_BIT]  = periph_in.clock_timer_output;
      p1_oe_n_next[gpm_pkg::P1_CLOCK_TIMER_OUTPUT_BIT] = 1'b0;
    end
  end

  always_comb begin
    p2_out_next  = p2_data_reg & p2_gpio;
    p2_oe_n_next = ~(p2_dir_reg & p2_gpio);
    if (func_sel_reg[gpm_pkg::FS_TXD]) begin
      p2_out_next[gpm_pkg::P2_TXD_BIT]  = periph_in.txd;
      p2_oe_n_next[gpm_pkg::P2_TXD_BIT] = 1'b0;
    end
    if (sck_out_sel) begin
      p2_out_next[gpm_pkg::P2_SCK_BIT]  = periph_in.sck_out;
      p2_oe_n_next[gpm_pkg::P2_SCK_BIT] = 1'b0;
    end
    // high side off, so a one releases the pin
    p2_oe_n_next = p2_oe_n_next | (p2_od_reg & p2_out_next & ~gpm_pkg::P2_OD_RSVD);
  end

  // Peripheral inputs see the pin only while handed over
  always_comb begin
    periph_next = '0;
    // interrupt three and timer trigger share pin 7
    periph_next.ext_interrupt_three = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_THREE] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_THREE];
    periph_next.timer_trigger_input = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_THREE] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_THREE];
    periph_next.ext_interrupt_two   = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_TWO] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_TWO];
    // interrupt one and timer-B event share pin 5
    periph_next.ext_interrupt_one   = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_ONE] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_ONE];
    periph_next.timer_b_event_input = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_ONE] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_ONE];
    periph_next.ext_interrupt_zero  = func_sel_reg[gpm_pkg::FS_EXT_INTERRUPT_ZERO] & p1_in[gpm_pkg::FS_EXT_INTERRUPT_ZERO];
    periph_next.rxd    = ser_ctrl_reg[gpm_pkg::SC_RE] & p2_in[gpm_pkg::P2_RXD_BIT];
    periph_next.sck_in = sck_in_sel & p2_in[gpm_pkg::P2_SCK_BIT];
    // second serial transmit gated by its select, handed out on periph_out
    periph_next.txd2_sel = func_sel_reg[gpm_pkg::FS_TXD2];
    periph_next.txd2     = func_sel_reg[gpm_pkg::FS_TXD2] & periph_in.txd2;
  end

  // port-one pins come out of reset as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_out       <= gpm_pkg::RST_CTRL;
      p1_oe_n      <= ~gpm_pkg::RST_CTRL;
      p1_pullup_on <= gpm_pkg::RST_CTRL;
    end else begin
      p1_out       <= p1_out_next;
      p1_oe_n      <= p1_oe_n_next;
      p1_pullup_on <= p1_pu_next;
    end
  end

  // port-two pins come out of reset as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_out  <= gpm_pkg::RST_CTRL;
      p2_oe_n <= ~gpm_pkg::RST_CTRL;
    end else begin
      p2_out  <= p2_out_next;
      p2_oe_n <= p2_oe_n_next;
    end
  end

  // Peripheral side held quiet in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_out <= '0;
    end else begin
      periph_out <= periph_next;
    end
  end

endmodule

`default_nettype wire

// file: test/gpm_ports_chk_asserts.sv
// Concurrent checks on the port mux block, bound into gpm_ports.
// Assumes the block's ports only; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module gpm_ports_chk (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic [31:0]              prdata,
  input wire logic [7:0]               p1_in,
  input wire logic [7:0]               p2_in,
  input wire logic [7:0]               p1_oe_n,
  input wire logic [7:0]               p1_pullup_on,
  input wire gpm_pkg::gpm_periph_out_s periph_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence
  a_ready_wait: assert property (s_access |=> s_pulse)
    else $error("pready not one cycle after access");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_high: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_bit3_idle: assert property (p1_oe_n[3])
    else $error("reserved pin driven");
  a_pullup_input: assert property ((p1_pullup_on[7:2] & ~p1_oe_n[7:2]) == 6'h00)
    else $error("pull-up on driven pin");
  a_trig_twin: assert property (
    periph_out.ext_interrupt_three == periph_out.timer_trigger_input)
    else $error("trigger differs from interrupt three");
  a_tmib_twin: assert property (
    periph_out.ext_interrupt_one == periph_out.timer_b_event_input)
    else $error("timer event differs from interrupt one");
  a_ext_interrupt_two_pin: assert property (periph_out.ext_interrupt_two |-> $past(p1_in[6]))
    else $error("interrupt two without pin");
  a_ext_interrupt_zero_pin: assert property (periph_out.ext_interrupt_zero |-> $past(p1_in[4]))
    else $error("interrupt zero without pin");
  a_rxd_pin: assert property (periph_out.rxd |-> $past(p2_in[1]))
    else $error("receive without pin");
  a_txd2_gate: assert property (!periph_out.txd2_sel |-> !periph_out.txd2)
    else $error("second transmit not gated");
endmodule
bind gpm_ports gpm_ports_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .p1_in(p1_in), .p2_in(p2_in), .p1_oe_n(p1_oe_n), .p1_pullup_on(p1_pullup_on),
  .periph_out(periph_out));
`default_nettype wire

// file: test/gpm_pin_model.sv
// Package pins outside the block: resolves each pad level.
// Assumes ext levels from the bench stand for outside drivers.
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_model (
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe_n,
  input  wire logic [7:0] p1_pullup_on,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe_n,
  input  wire logic [7:0] ext1,
  input  wire logic [7:0] ext2,
  output logic      [7:0] p1_in,
  output logic      [7:0] p2_in
);
  assign p1_in = (~p1_oe_n & p1_out) | (p1_oe_n & (p1_pullup_on | ext1));
  assign p2_in = (~p2_oe_n & p2_out) | (p2_oe_n & ext2);
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the port mux block over APB.
// Assumes one wait state per transfer and pins one edge behind.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                     pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                     penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]               paddr = 8'h00, ext1 = 8'h52, ext2 = 8'hc3;
  logic [7:0]               p1_in, p2_in, p1_out, p1_oe_n, p1_pullup_on, p2_out, p2_oe_n;
  logic [31:0]              pwdata = 32'h0, prdata, r;
  gpm_pkg::gpm_periph_in_s  pi = 5'h00;
  gpm_pkg::gpm_periph_out_s po;
  int                       failures = 0, checked = 0, cyc = 0;
  gpm_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .p1_in(p1_in), .p1_out(p1_out), .p1_oe_n(p1_oe_n),
    .p1_pullup_on(p1_pullup_on), .p2_in(p2_in), .p2_out(p2_out), .p2_oe_n(p2_oe_n),
    .periph_in(pi), .periph_out(po));
  gpm_pin_model u_pins (.p1_out(p1_out), .p1_oe_n(p1_oe_n), .p1_pullup_on(p1_pullup_on),
    .p2_out(p2_out), .p2_oe_n(p2_oe_n), .ext1(ext1), .ext2(ext2), .p1_in(p1_in),
    .p2_in(p2_in));
  always #50 pclk = ~pclk;
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset;
    rd(gpm_pkg::OFS_FUNC_SEL, 32'h00);
    rd(gpm_pkg::OFS_P1_DIR, 32'h00);
    rd(gpm_pkg::OFS_P1_DATA, 32'h5a);
    rd(gpm_pkg::OFS_P1_PULLUP, 32'h08);
    rd(gpm_pkg::OFS_P2_DATA, 32'hc3);
    rd(gpm_pkg::OFS_P2_OD, 32'h07);
    chk("oe_n", 32'hffff, {p2_oe_n, p1_oe_n});
    chk("pullup", 32'h0, {p1_pullup_on, po});
  endtask
  task automatic t_gpio;
    wr(gpm_pkg::OFS_P1_DATA, 8'ha5);
    wr(gpm_pkg::OFS_P1_DIR, 8'hf0);
    wr(gpm_pkg::OFS_P2_DATA, 8'h3c);
    wr(gpm_pkg::OFS_P2_DIR, 8'h0f);
    settle;
    rd(gpm_pkg::OFS_P1_DATA, 32'haa);
    chk("p1_oe_n", 32'h0f, p1_oe_n);
    chk("p1_out", 32'ha0, p1_out & 8'hf0);
    rd(gpm_pkg::OFS_P2_DATA, 32'hcc);
    chk("p2_oe_n", 32'hf0, p2_oe_n);
  endtask
  task automatic t_pullup;
    wr(gpm_pkg::OFS_P1_PULLUP, 8'hff);
    settle;
    chk("pullup", 32'h07, p1_pullup_on);
    rd(gpm_pkg::OFS_P1_PULLUP, 32'hff);
    wr(gpm_pkg::OFS_P1_DIR, 8'h00);
    settle;
    chk("pullup", 32'hf7, p1_pullup_on);
    rd(gpm_pkg::OFS_P1_DATA, 32'hff);
    wr(gpm_pkg::OFS_P1_PULLUP, 8'h00);
  endtask
  task automatic t_func;
    ext1 <= 8'hf0;
    wr(gpm_pkg::OFS_P1_DIR, 8'hff);
    wr(gpm_pkg::OFS_P2_DIR, 8'h00);
    wr(gpm_pkg::OFS_FUNC_SEL, 8'hf0);
    settle;
    chk("irq", 32'h3f, {po.ext_interrupt_three, po.timer_trigger_input,
      po.ext_interrupt_two, po.ext_interrupt_one, po.timer_b_event_input,
      po.ext_interrupt_zero});
    chk("irq_oe_n", 32'hf0, p1_oe_n & 8'hf0);
    pi <= 5'h12;
    wr(gpm_pkg::OFS_P1_DIR, 8'h00);
    wr(gpm_pkg::OFS_FUNC_SEL, 8'h0f);
    settle;
    chk("p1_periph", 32'h2, {p1_oe_n[1:0], p1_out[1:0]});
    chk("txd", 32'h0, {p2_oe_n[2], p2_out[2]});
    chk("txd2", 32'h3, {po.txd2_sel, po.txd2});
    wr(gpm_pkg::OFS_FUNC_SEL, 8'h00);
    ext1 <= 8'h52;
  endtask
  task automatic t_od;
    wr(gpm_pkg::OFS_P2_DATA, 8'ha8);
    wr(gpm_pkg::OFS_P2_DIR, 8'hf8);
    wr(gpm_pkg::OFS_P2_OD, 8'hf8);
    settle;
    chk("od_oe_n", 32'h15, p2_oe_n[7:3]);
    rd(gpm_pkg::OFS_P2_OD, 32'hff);
    wr(gpm_pkg::OFS_P2_OD, 8'h00);
    settle;
    chk("pp_oe_n", 32'h00, p2_oe_n[7:3]);
  endtask
  task automatic t_serial;
    logic [3:0] cv[7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h4, 4'h6, 4'h5};
    logic [4:0] ev[7] = '{5'h00, 5'h18, 5'h02, 5'h02, 5'h05, 5'h05, 5'h1d};
    pi <= 5'h01;
    wr(gpm_pkg::OFS_P2_DIR, 8'hff);
    wr(gpm_pkg::OFS_P2_DATA, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(gpm_pkg::OFS_SER_CTRL, {4'h0, cv[i]});
      settle;
      chk("serial", ev[i], {p2_oe_n[1], po.rxd, p2_oe_n[0], p2_out[0] & ~p2_oe_n[0],
        po.sck_in});
    end
    wr(gpm_pkg::OFS_SER_CTRL, 8'h00);
  endtask
  task automatic t_unmapped;
    wr(8'h20, 8'hff);
    chk("slverr", 32'h1, err);
    rd(8'h20, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gpio;
    t_pullup;
    t_func;
    t_od;
    t_serial;
    t_unmapped;
    // Mid-run reset must clear every written control
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    test_done;
  end
endmodule
`default_nettype wire
